// ===== include/flash_regs_pkg.sv
// constants and types shared by the flash register bank
`default_nettype none
package flash_regs_pkg;
	// ****************
	// command codes
	// ****************
	localparam logic [7:0] CMD_RD_FLAG = 8'h70;
	localparam logic [7:0] CMD_CLR_FLAG = 8'h50;
	localparam logic [7:0] CMD_RD_EVCR = 8'h65;
	localparam logic [7:0] CMD_WR_EVCR = 8'h61;
	localparam logic [7:0] CMD_RD_SEG = 8'hC8;
	localparam logic [7:0] CMD_WR_SEG = 8'hC5;

	// ****************
	// layout and reset values
	// ****************
	localparam int ADDR_W = 25;
	localparam int HALF_W = 24;
	localparam int SEG_SEL_BIT = 0;
	localparam int NV_SEG_BIT = 1;
	localparam logic [7:0] SEG_RESET = 8'h00;
	localparam logic [7:0] EVCR_RESET = 8'hDF;
	localparam logic [2:0] DRIVE_RSVD_LO = 3'h0;
	localparam logic [2:0] DRIVE_RSVD_HI = 3'h4;
	localparam logic [24:0] ADDR_STEP = 25'h0000001;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [1:0] BYTES_NONE = 2'h0;
	localparam logic [1:0] BYTES_CMD = 2'h1;
	localparam logic [1:0] BYTES_DATA = 2'h2;

	// ****************
	// types
	// ****************
	typedef struct packed {
		logic quad_n;
		logic dual_n;
		logic rsvd;
		logic hold_en;
		logic accel_n;
		logic [2:0] drive;
	} evcr_t;

	typedef struct packed {
		logic ready;
		logic erase_susp;
		logic erase_err;
		logic prog_err;
		logic accel_err;
		logic prog_susp;
		logic prot_err;
		logic addr4;
	} flag_t;

	typedef struct packed {
		logic busy;
		logic erase_susp;
		logic prog_susp;
		logic addr4;
	} status_in_t;

	typedef struct packed {
		logic erase_fail;
		logic erase_prot;
		logic program_fail;
		logic program_prot;
		logic otp_locked;
		logic raise_fault;
		logic accel_fault;
	} err_evt_t;

	typedef enum logic [1:0] {op_read, op_program, op_erase, op_bulk_erase} op_kind_t;
	typedef enum logic [1:0] {proto_extended, proto_dual, proto_quad} proto_t;
endpackage
`default_nettype wire

// ===== hdl/flash_segment_config_flag_regs.sv
// segment, enhanced volatile configuration and flag status registers
`default_nettype none
module flash_segment_config_flag_regs
	import flash_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so_q,
	output logic so_oe_n_q,
	input wire logic [15:0] nv_config,
	input wire status_in_t status_in,
	input wire err_evt_t err_evt,
	input wire logic op_valid,
	input wire op_kind_t op_kind,
	input wire logic [31:0] op_addr,
	input wire logic read_next,
	output logic [24:0] array_addr_q,
	output logic erase_all_q,
	output proto_t protocol_q,
	output logic hold_en_q,
	output logic accel_en_q,
	output logic [2:0] drive_q,
	output logic [7:0] segment_q,
	output flag_t flag_q
);
	// ****************
	// serial side, sclk domain
	// ****************
	logic [2:0] bit_q;
	logic [2:0] bit_d;
	logic [1:0] byte_q;
	logic [1:0] byte_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic cmd_full_q;
	logic cmd_full_d;
	logic data_full_q;
	logic data_full_d;
	logic [7:0] sh;

	// counters end with the frame: chip select high clears them
	always_comb begin
		bit_d = bit_q + 3'h1;
		byte_d = byte_q;
		if (bit_q == BIT_LAST && byte_q != BYTES_DATA) begin
			byte_d = byte_q + 2'h1;
		end
	end
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_q <= BIT_FIRST;
			byte_q <= BYTES_NONE;
		end else begin
			bit_q <= bit_d;
			byte_q <= byte_d;
		end
	end

	// captured bytes stay put after the frame so the core can read them
	always_comb begin
		sh = {shift_q[6:0], si};
		shift_d = sh;
		cmd_d = cmd_q;
		data_d = data_q;
		cmd_full_d = cmd_full_q;
		data_full_d = data_full_q;
		if (bit_q == BIT_FIRST && byte_q == BYTES_NONE) begin
			cmd_full_d = 1'b0;
			data_full_d = 1'b0;
		end
		if (bit_q == BIT_LAST && byte_q == BYTES_NONE) begin
			cmd_d = sh;
			cmd_full_d = 1'b1;
		end
		if (bit_q == BIT_LAST && byte_q == BYTES_CMD) begin
			data_d = sh;
			data_full_d = 1'b1;
		end
	end
	always_ff @(posedge sclk) begin
		shift_q <= shift_d;
		cmd_q <= cmd_d;
		data_q <= data_d;
		cmd_full_q <= cmd_full_d;
		data_full_q <= data_full_d;
	end

	// ****************
	// register images into the sclk domain
	// ****************
	// segment and configuration fields change only between frames, flag bits can change at any time; each image is two flops
	logic [7:0] flag_s1_q;
	logic [7:0] flag_s2_q;
	logic [7:0] evcr_s1_q;
	logic [7:0] evcr_s2_q;
	logic [7:0] seg_s1_q;
	logic [7:0] seg_s2_q;
	evcr_t evcr_q;
	evcr_t evcr_d;
	always_ff @(posedge sclk) begin
		flag_s1_q <= flag_q;
		flag_s2_q <= flag_s1_q;
		evcr_s1_q <= evcr_q;
		evcr_s2_q <= evcr_s1_q;
		seg_s1_q <= segment_q;
		seg_s2_q <= seg_s1_q;
	end

	// ****************
	// read path, sclk domain
	// ****************
	// read data leaves on the falling edge, repeating the register byte
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic so_d;
	logic oe_n_d;
	always_comb begin
		rd_byte = flag_s2_q;
		rd_hit = 1'b1;
		if (cmd_q == CMD_RD_FLAG) begin
			rd_byte = flag_s2_q;
		end else if (cmd_q == CMD_RD_EVCR) begin
			rd_byte = evcr_s2_q;
		end else if (cmd_q == CMD_RD_SEG) begin
			rd_byte = seg_s2_q;
		end else begin
			rd_hit = 1'b0;
		end
		tx_d = {tx_q[6:0], 1'b0};
		so_d = tx_q[7];
		oe_n_d = so_oe_n_q;
		if (bit_q == BIT_FIRST && byte_q != BYTES_NONE) begin
			tx_d = {rd_byte[6:0], 1'b0};
			so_d = rd_byte[7];
			oe_n_d = ~(rd_hit & cmd_full_q);
		end
	end
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_q <= 8'h00;
			so_q <= 1'b0;
			so_oe_n_q <= 1'b1;
		end else begin
			tx_q <= tx_d;
			so_q <= so_d;
			so_oe_n_q <= oe_n_d;
		end
	end

	// ****************
	// chip select release, clk domain
	// ****************
	// a level counts only once two stages agree, so a glitch never commits a frame
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic cs_hi_q;
	logic cs_hi_d;
	logic cs_rise;
	always_comb begin
		cs_hi_d = cs_hi_q;
		if (cs_s2_q == cs_s3_q) begin
			cs_hi_d = cs_s3_q;
		end
		cs_rise = cs_hi_d & ~cs_hi_q;
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			cs_hi_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			cs_hi_q <= cs_hi_d;
		end
	end

	// ****************
	// register bank
	// ****************
	logic [7:0] seg_d;
	flag_t flag_d;
	logic strap_q;
	logic strap_d;
	logic errs_any;
	logic commit;
	logic wr_cmd;
	logic wr_ok;

	// frame decode shared by both register groups
	always_comb begin
		errs_any = flag_q.erase_err | flag_q.prog_err | flag_q.accel_err | flag_q.prot_err;
		commit = cs_rise & cmd_full_q;
		wr_cmd = cmd_q == CMD_WR_SEG || cmd_q == CMD_WR_EVCR;
		// a write refused for a pending error must not land
		wr_ok = commit & data_full_q & ~errs_any;
	end

	// ****************
	// segment and configuration registers
	// ****************
	always_comb begin
		seg_d = segment_q;
		evcr_d = evcr_q;
		strap_d = 1'b1;
		if (!strap_q) begin
			seg_d[SEG_SEL_BIT] = nv_config[NV_SEG_BIT];
		end
		if (wr_ok && cmd_q == CMD_WR_SEG) begin
			seg_d[SEG_SEL_BIT] = data_q[SEG_SEL_BIT];
		end else if (wr_ok && cmd_q == CMD_WR_EVCR) begin
			evcr_d = data_q;
			evcr_d.rsvd = 1'b0;
			// a reserved drive code would leave the pad undefined, keep the old one
			if (data_q[2:0] == DRIVE_RSVD_LO || data_q[2:0] == DRIVE_RSVD_HI) begin
				evcr_d.drive = evcr_q.drive;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			segment_q <= SEG_RESET;
			evcr_q <= EVCR_RESET;
			strap_q <= 1'b0;
		end else begin
			segment_q <= seg_d;
			evcr_q <= evcr_d;
			strap_q <= strap_d;
		end
	end

	// ****************
	// flag status register
	// ****************
	always_comb begin
		flag_d = flag_q;
		// status bits follow the controller each cycle
		flag_d.ready = ~status_in.busy;
		flag_d.erase_susp = status_in.erase_susp;
		flag_d.prog_susp = status_in.prog_susp;
		flag_d.addr4 = status_in.addr4;
		if (commit && cmd_q == CMD_CLR_FLAG) begin
			flag_d.erase_err = 1'b0;
			flag_d.prog_err = 1'b0;
			flag_d.accel_err = 1'b0;
			flag_d.prot_err = 1'b0;
		end else if (commit && wr_cmd && errs_any) begin
			flag_d.prot_err = 1'b1;
		end
		// hardware sets win over a clear in the same cycle
		if (err_evt.erase_fail || err_evt.erase_prot) begin
			flag_d.erase_err = 1'b1;
		end
		if (err_evt.program_fail || err_evt.program_prot || err_evt.otp_locked || err_evt.raise_fault) begin
			flag_d.prog_err = 1'b1;
		end
		if (err_evt.accel_fault) begin
			flag_d.accel_err = 1'b1;
		end
		if (err_evt.erase_prot || err_evt.program_prot || err_evt.otp_locked) begin
			flag_d.prot_err = 1'b1;
		end
		if (op_valid && op_kind != op_read && errs_any) begin
			flag_d.prot_err = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flag_q <= '{ready: 1'b1, default: 1'b0};
		end else begin
			flag_q <= flag_d;
		end
	end

	// ****************
	// configuration outputs and array address
	// ****************
	logic [24:0] addr_d;
	logic all_d;
	logic hold_d;
	logic accel_d;
	proto_t proto_d;

	// outputs register the next value so they move together with the register
	always_comb begin
		proto_d = proto_extended;
		if (!evcr_d.quad_n) begin
			proto_d = proto_quad;
		end else if (!evcr_d.dual_n) begin
			proto_d = proto_dual;
		end
		hold_d = evcr_d.hold_en;
		accel_d = ~evcr_d.accel_n;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			protocol_q <= proto_extended;
			hold_en_q <= 1'b1;
			accel_en_q <= 1'b0;
			drive_q <= 3'h7;
		end else begin
			protocol_q <= proto_d;
			hold_en_q <= hold_d;
			accel_en_q <= accel_d;
			drive_q <= evcr_d.drive;
		end
	end

	// ****************
	// array address
	// ****************
	always_comb begin
		addr_d = array_addr_q;
		all_d = erase_all_q;
		if (op_valid) begin
			all_d = op_kind == op_bulk_erase;
			if (status_in.addr4) begin
				addr_d = op_addr[ADDR_W-1:0];
			end else begin
				addr_d = {segment_q[SEG_SEL_BIT], op_addr[HALF_W-1:0]};
			end
		end else if (read_next) begin
			// natural rollover gives the top-to-zero wrap, segment stays as is
			addr_d = array_addr_q + ADDR_STEP;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			array_addr_q <= 25'h0000000;
			erase_all_q <= 1'b0;
		end else begin
			array_addr_q <= addr_d;
			erase_all_q <= all_d;
		end
	end
endmodule
`default_nettype wire

// ===== sim/spi_host_model.sv
// spi host model issuing register command frames
`default_nettype none
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so_q,
	input wire logic so_oe_n_q
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 0;
		cs_n = 1;
		si = 0;
	end
	// sclk parks low between frames; unknown shifted in when so not driven
	task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		#7 cs_n = 0;
		for (int i = 0; i < n; i++) begin
			si = tx[15 - i];
			#15 sclk = 1;
			if (i > 7)
				rx = {rx[6:0], so_oe_n_q ? 1'bx : so_q};
			#15 sclk = 0;
		end
		#15 cs_n = 1;
		// released line flips so a stale bit is never mistaken for data
		si = ~si;
		#100;
	endtask
endmodule
`default_nettype wire

// ===== sim/flash_regs_sva.sv
// checker for the flash register bank outputs
`default_nettype none
module flash_regs_sva
	import flash_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire status_in_t status_in,
	input wire err_evt_t err_evt,
	input wire logic op_valid,
	input wire op_kind_t op_kind,
	input wire logic [31:0] op_addr,
	input wire logic read_next,
	input wire logic [24:0] array_addr_q,
	input wire logic erase_all_q,
	input wire logic [7:0] segment_q,
	input wire flag_t flag_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_op3;
		op_valid && !status_in.addr4;
	endsequence
	chk_addr_three: assert property (s_op3 |=> array_addr_q == {$past(segment_q[0]), $past(op_addr[23:0])})
		else $error("segment address wrong");
	chk_addr_four: assert property (op_valid && status_in.addr4 |=> array_addr_q == $past(op_addr[24:0]))
		else $error("full address wrong");
	chk_read_step: assert property (read_next && !op_valid |=> array_addr_q == $past(array_addr_q) + 25'h0000001)
		else $error("read step wrong");
	chk_seg_kept: assert property (read_next |=> $stable(segment_q))
		else $error("segment moved on read");
	chk_bulk_all: assert property (op_valid && op_kind == op_bulk_erase |=> erase_all_q)
		else $error("bulk erase not whole");
	chk_ready_live: assert property (1 |=> flag_q.ready == !$past(status_in.busy))
		else $error("ready bit wrong");
	chk_status_live: assert property (1 |=> {flag_q.erase_susp, flag_q.prog_susp, flag_q.addr4} ==
		$past({status_in.erase_susp, status_in.prog_susp, status_in.addr4}))
		else $error("status bits wrong");
	chk_new_cmd: assert property (op_valid && op_kind != op_read &&
		(flag_q.erase_err || flag_q.prog_err || flag_q.accel_err || flag_q.prot_err) |=> flag_q.prot_err)
		else $error("command under error not flagged");
	chk_erase_err: assert property (err_evt.erase_fail || err_evt.erase_prot |=> flag_q.erase_err)
		else $error("erase error missed");
	chk_prog_err: assert property (err_evt.program_fail || err_evt.raise_fault |=> flag_q.prog_err)
		else $error("program error missed");
	chk_accel_err: assert property (err_evt.accel_fault |=> flag_q.accel_err)
		else $error("supply error missed");
	chk_prot_err: assert property (err_evt.otp_locked || err_evt.program_prot |=> flag_q.prot_err)
		else $error("protection error missed");
endmodule
bind flash_segment_config_flag_regs flash_regs_sva u_chk (.*);
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the flash register bank
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t got %h", $time, a); end end
module tb_top
	import flash_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, op_valid = 0, read_next = 0, sg = 1;
	logic sclk, cs_n, si, so_q, so_oe_n_q, erase_all_q, hold_en_q, accel_en_q;
	logic [15:0] nv_config = 16'h0002;
	status_in_t status_in = '0;
	err_evt_t err_evt = '0;
	op_kind_t op_kind = op_read;
	logic [31:0] op_addr = '0;
	logic [24:0] array_addr_q;
	proto_t protocol_q;
	logic [2:0] drive_q, drv;
	logic [7:0] segment_q, rx, v;
	flag_t flag_q;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	logic [7:0] err_exp [0:6] = '{8'h08, 8'h10, 8'h12, 8'h12, 8'h10, 8'h22, 8'h20};
	always #5 clk = ~clk;
	flash_segment_config_flag_regs dut (.*);
	spi_host_model host (.*);
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic op(op_kind_t k, logic [31:0] a);
		op_kind = k;
		op_addr = a;
		op_valid = 1;
		tick(1);
		op_valid = 0;
	endtask
	function automatic proto_t exp_proto(logic [7:0] e);
		return !e[7] ? proto_quad : !e[6] ? proto_dual : proto_extended;
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'hB5B51456));
		tick(2);
		reset_n = 1;
		tick(3);
		`CHK(segment_q, 8'h01)
		`CHK({protocol_q, hold_en_q, accel_en_q, drive_q}, {proto_extended, 5'b10111})
		host.xfer({CMD_RD_FLAG, 8'h00}, 16, rx);
		`CHK(rx, 8'h80)
		for (int i = 0; i < 24; i++) begin
			status_in = {3'b000, 1'($urandom)};
			v = 8'($urandom);
			op(op_kind_t'(v[1:0] % 3), $urandom);
			`CHK(array_addr_q, status_in.addr4 ? op_addr[24:0] : {sg, op_addr[23:0]})
		end
		status_in = '0;
		tick(1);
		op(op_read, 32'h00FFFFFF);
		read_next = 1;
		tick(1);
		read_next = 0;
		`CHK({array_addr_q, segment_q}, {25'h0000000, 8'h01})
		op(op_bulk_erase, $urandom);
		`CHK(erase_all_q, 1'b1)
		host.xfer({CMD_WR_SEG, 8'hFE}, 16, rx);
		host.xfer({CMD_RD_SEG, 8'h00}, 16, rx);
		`CHK({segment_q, rx}, 16'h0000)
		host.xfer({CMD_WR_SEG, 8'hFF}, 12, rx);
		`CHK(segment_q, 8'h00)
		drv = 3'h7;
		for (int i = 0; i < 12; i++) begin
			v = i == 0 ? 8'h00 : i == 1 ? 8'h7C : i == 2 ? 8'hBD : 8'($urandom);
			host.xfer({CMD_WR_EVCR, v}, 16, rx);
			if (v[2:0] != DRIVE_RSVD_LO && v[2:0] != DRIVE_RSVD_HI)
				drv = v[2:0];
			`CHK({protocol_q, hold_en_q, accel_en_q, drive_q}, {exp_proto(v), v[4], !v[3], drv})
			host.xfer({CMD_RD_EVCR, 8'h00}, 16, rx);
			`CHK(rx, {v[7:6], 1'b0, v[4:3], drv})
		end
		for (int i = 0; i < 8; i++) begin
			status_in = 4'($urandom);
			tick(2);
			`CHK(flag_q, {!status_in.busy, status_in.erase_susp, 3'b000, status_in.prog_susp, 1'b0, status_in.addr4})
		end
		status_in = '0;
		for (int i = 0; i < 7; i++) begin
			host.xfer({CMD_CLR_FLAG, 8'h00}, 8, rx);
			`CHK(flag_q, 8'h80)
			err_evt = 7'(1 << i);
			tick(1);
			err_evt = '0;
			tick(2);
			`CHK(flag_q, 8'h80 | err_exp[i])
		end
		host.xfer({CMD_WR_SEG, 8'h01}, 16, rx);
		`CHK({flag_q, segment_q}, 16'hA200)
		host.xfer({CMD_CLR_FLAG, 8'h00}, 8, rx);
		`CHK(flag_q, 8'h80)
		err_evt = 7'h40;
		tick(1);
		err_evt = '0;
		op(op_program, $urandom);
		`CHK(flag_q, 8'hA2)
		host.xfer({CMD_CLR_FLAG, 8'h00}, 8, rx);
		`CHK(flag_q, 8'h80)
		conclude();
	end
endmodule
`default_nettype wire
